//--- design/synth_serial_program_port.v
/*
 Serial programming port of a frequency synthesizer: a 20-bit shift
 register, three destination latches, feedback ratio arithmetic and the
 receive/transmit chain sleep control.
 Assumes clock, data and strobe come from a host outside the mclk domain;
 each is synchronised here; clock and strobe edges are found by sampling.
*/
`timescale 1ns/1ns
`include "synth_port_defs.vh"

// Contract
// - 20-bit shifter feeds function, feedback, reference latches
// - Data sampled on rising serial clock, MSB first
// - Last two shifted bits select the destination
// - Strobe rising edge copies data to chosen latch
// - 00 feedback, 10 reference, x1 function latch
// - Code 00 loads swallow and main 6-bit latches
// - Swallow ratio binary, feedback bits one to six
// - Code 10 loads reference ratio, host keeps 3..63
// - Feedback divide is modulus times main plus swallow
// - Receive sleep by pin or latch bit per method
// - Transmit sleep by pin or latch bit per method
// - Method 00 software, 11 pin, others reserved
// - Pin low sleeps chain; software bit one sleeps
// - Latches kept through power-down; host initialises once
module synth_serial_program_port (
   // Clock and reset
   input  wire                         mclk,
   input  wire                         rst,
   // Serial port from host
   input  wire                         serialClock,
   input  wire                         serialData,
   input  wire                         loadStrobe,
   // Chain sleep pins
   input  wire                         receiveChainSleepPin,
   input  wire                         transmitChainSleepPin,
   // Latch contents
   output reg  [`FUNC_WIDTH-1:0]       functionControlLatch,
   output reg  [`SWALLOW_WIDTH-1:0]    swallowRatio,
   output reg  [`MAIN_WIDTH-1:0]       mainRatio,
   output reg  [`REF_WIDTH-1:0]        referenceRatio,
   // Derived controls
   output reg  [12:0]                  feedbackDivide,
   output reg                          receiveChainOff,
   output reg                          transmitChainOff,
   output reg                          methodReserved
);

   // ----------------------------------------
   // Pin indices
   // ----------------------------------------
   localparam PIN_CLOCK    = 0;
   localparam PIN_DATA     = 1;
   localparam PIN_STROBE   = 2;
   localparam PIN_RX_SLEEP = 3;
   localparam PIN_TX_SLEEP = 4;
   localparam PIN_COUNT    = 5;
   localparam CHAIN_COUNT  = 2;

   localparam [PIN_COUNT-1:0] SYNC_IDLE = `SYNC_IDLE;

   // ----------------------------------------
   // Decode functions
   // ----------------------------------------
   function isFunctionTarget;
      input [1:0] code;
      begin
         isFunctionTarget = code[0];
      end
   endfunction

   function isReferenceTarget;
      input [1:0] code;
      begin
         isReferenceTarget = (code == `DEST_REFERENCE);
      end
   endfunction

   function isFeedbackTarget;
      input [1:0] code;
      begin
         isFeedbackTarget = (code == `DEST_FEEDBACK);
      end
   endfunction

   function methodIsPin;
      input [1:0] code;
      begin
         methodIsPin = (code == `METHOD_PIN);
      end
   endfunction

   function methodIsReserved;
      input [1:0] code;
      begin
         methodIsReserved = (code != `METHOD_SOFT) && (code != `METHOD_PIN);
      end
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   wire [PIN_COUNT-1:0] pinRaw;
   wire [PIN_COUNT-1:0] pinSync;

   assign pinRaw = {transmitChainSleepPin, receiveChainSleepPin, loadStrobe, serialData, serialClock};

   // Reset to each pin's idle level so no false edge follows reset.
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : pin_sync
         reg stageA;
         reg stageB;

         always @(posedge mclk) begin
            if (rst) begin
               stageA <= SYNC_IDLE[gi];
               stageB <= SYNC_IDLE[gi];
            end else begin
               stageA <= pinRaw[gi];
               stageB <= stageA;
            end
         end

         assign pinSync[gi] = stageB;
      end
   endgenerate

   // ----------------------------------------
   // Edge detection
   // ----------------------------------------
   reg clockLast;
   reg strobeLast;
   reg dataHeld;

   always @(posedge mclk) begin
      if (rst) begin
         clockLast <= SYNC_IDLE[PIN_CLOCK];
         strobeLast <= SYNC_IDLE[PIN_STROBE];
         dataHeld <= SYNC_IDLE[PIN_DATA];
      end else begin
         clockLast <= pinSync[PIN_CLOCK];
         strobeLast <= pinSync[PIN_STROBE];
         dataHeld <= pinSync[PIN_DATA];
      end
   end

   // Data is taken one sample early, from the sample that pairs with the
   // clock still low, so the host's setup time covers the data path.
   wire clockRise  = pinSync[PIN_CLOCK] & ~clockLast;
   wire strobeRise = pinSync[PIN_STROBE] & ~strobeLast;

   // ----------------------------------------
   // Shift register
   // ----------------------------------------
   reg [`SHIFT_WIDTH-1:0] shiftWord;
   reg [`SHIFT_WIDTH-1:0] next_shiftWord;

   always @* begin
      next_shiftWord = shiftWord;
      if (clockRise) begin
         next_shiftWord = {shiftWord[`SHIFT_WIDTH-2:0], dataHeld};
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         shiftWord <= `SHIFT_RESET;
      end else begin
         shiftWord <= next_shiftWord;
      end
   end

   // ----------------------------------------
   // Destination decode
   // ----------------------------------------
   wire [1:0] destCode = shiftWord[1:0];

   wire loadFunction  = strobeRise & isFunctionTarget(destCode);
   wire loadReference = strobeRise & isReferenceTarget(destCode);
   wire loadFeedback  = strobeRise & isFeedbackTarget(destCode);

   // ----------------------------------------
   // Function latch
   // ----------------------------------------
   reg [`FUNC_WIDTH-1:0] next_functionControlLatch;

   always @* begin
      next_functionControlLatch = functionControlLatch;
      if (loadFunction) begin
         next_functionControlLatch = shiftWord[`SHIFT_WIDTH-1:2];
      end
   end

   // Power-up reset only; rst models that, so latches clear here and
   // nothing else ever clears them.
   always @(posedge mclk) begin
      if (rst) begin
         functionControlLatch <= `FUNC_RESET;
      end else begin
         functionControlLatch <= next_functionControlLatch;
      end
   end

   // ----------------------------------------
   // Reference divider latch
   // ----------------------------------------
   reg [`REF_WIDTH-1:0] next_referenceRatio;

   always @* begin
      next_referenceRatio = referenceRatio;
      if (loadReference) begin
         next_referenceRatio = shiftWord[`REF_WIDTH+1:2];
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         referenceRatio <= `RATIO_RESET;
      end else begin
         referenceRatio <= next_referenceRatio;
      end
   end

   // ----------------------------------------
   // Feedback divider latches
   // ----------------------------------------
   reg [`SWALLOW_WIDTH-1:0] next_swallowRatio;
   reg [`MAIN_WIDTH-1:0]    next_mainRatio;

   always @* begin
      next_swallowRatio = swallowRatio;
      next_mainRatio = mainRatio;
      if (loadFeedback) begin
         next_swallowRatio = shiftWord[`SWALLOW_WIDTH+1:2];
         next_mainRatio = shiftWord[`SWALLOW_WIDTH+`MAIN_WIDTH+1:`SWALLOW_WIDTH+2];
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         swallowRatio <= `RATIO_RESET;
         mainRatio <= `RATIO_RESET;
      end else begin
         swallowRatio <= next_swallowRatio;
         mainRatio <= next_mainRatio;
      end
   end

   // ----------------------------------------
   // Feedback ratio
   // ----------------------------------------
   wire [6:0]  modulus = functionControlLatch[`FBIT_PRESCALER] ? `PRESCALE_HIGH : `PRESCALE_LOW;
   wire [12:0] product = modulus * mainRatio;
   wire [12:0] next_feedbackDivide;

   // Swallow above modulus or main is the host's fault; no clamp.
   assign next_feedbackDivide = product + {7'h00, swallowRatio};

   always @(posedge mclk) begin
      if (rst) begin
         feedbackDivide <= `DIVIDE_RESET;
      end else begin
         feedbackDivide <= next_feedbackDivide;
      end
   end

   // ----------------------------------------
   // Chain sleep
   // ----------------------------------------
   wire [1:0] method = {functionControlLatch[`FBIT_METHOD_HI], functionControlLatch[`FBIT_METHOD_LO]};

   wire [CHAIN_COUNT-1:0] chainPin;
   wire [CHAIN_COUNT-1:0] chainBit;
   wire [CHAIN_COUNT-1:0] next_chainOff;

   assign chainPin = {pinSync[PIN_TX_SLEEP], pinSync[PIN_RX_SLEEP]};
   assign chainBit = {functionControlLatch[`FBIT_TX_SLEEP], functionControlLatch[`FBIT_RX_SLEEP]};

   // Reserved test codes fall back to software control.
   genvar gc;
   generate
      for (gc = 0; gc < CHAIN_COUNT; gc = gc + 1) begin : chain_sleep
         assign next_chainOff[gc] = methodIsPin(method) ? ~chainPin[gc] : chainBit[gc];
      end
   endgenerate

   always @(posedge mclk) begin
      if (rst) begin
         receiveChainOff <= 1'b0;
         transmitChainOff <= 1'b0;
         methodReserved <= 1'b0;
      end else begin
         receiveChainOff <= next_chainOff[0];
         transmitChainOff <= next_chainOff[1];
         methodReserved <= methodIsReserved(method);
      end
   end

endmodule // synth_serial_program_port

//--- pkg/synth_port_defs.vh
/*
 Constants for the synthesizer serial programming port: word layout,
 destination codes, function-latch bit positions and sleep methods.
 Assumes inclusion by bare name from design files.
*/
`ifndef SYNTH_PORT_DEFS_VH
`define SYNTH_PORT_DEFS_VH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define SHIFT_WIDTH     20
`define FUNC_WIDTH      18
`define FEEDBACK_WIDTH  12
`define REF_WIDTH       6
`define SWALLOW_WIDTH   6
`define MAIN_WIDTH      6

// ----------------------------------------
// Destination codes {high, low}
// ----------------------------------------
`define DEST_FEEDBACK   2'b00
`define DEST_REFERENCE  2'b10

// ----------------------------------------
// Function latch bit positions (0-based)
// ----------------------------------------
`define FBIT_PRESCALER  0
`define FBIT_RX_SLEEP   5
`define FBIT_TX_SLEEP   6
`define FBIT_METHOD_LO  10
`define FBIT_METHOD_HI  11

// ----------------------------------------
// Sleep methods {hi, lo}
// ----------------------------------------
`define METHOD_SOFT     2'b00
`define METHOD_PIN      2'b11

// ----------------------------------------
// Prescaler moduli
// ----------------------------------------
`define PRESCALE_LOW    7'h20
`define PRESCALE_HIGH   7'h40

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SHIFT_RESET     20'h00000
`define FUNC_RESET      18'h00000
`define RATIO_RESET     6'h00
`define DIVIDE_RESET    13'h0000
// Sleep pins idle high, serial pins idle low
`define SYNC_IDLE       5'h18

`endif

//--- verif/synth_port_chk.sv
/* Checker for the serial programming port: sees only the top ports.
   Assumes mclk samples every port and rst is synchronous. */
`timescale 1ns/1ns
module synth_port_chk (
   input wire        mclk, rst, serialClock, serialData, loadStrobe, receiveChainSleepPin, transmitChainSleepPin,
   input wire [17:0] functionControlLatch,
   input wire [5:0]  swallowRatio, mainRatio, referenceRatio,
   input wire [12:0] feedbackDivide,
   input wire        receiveChainOff, transmitChainOff, methodReserved
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   feedback_ratio_a: assert property (feedbackDivide == (($past(functionControlLatch[0]) ? 13'd64 : 13'd32)
      * {7'h0, $past(mainRatio)} + {7'h0, $past(swallowRatio)})) else $error("feedback ratio wrong");
   rx_soft_a: assert property ((functionControlLatch[11:10] == 2'b00)[*2] |->
      receiveChainOff == $past(functionControlLatch[5])) else $error("rx soft sleep wrong");
   tx_soft_a: assert property ((functionControlLatch[11:10] == 2'b00)[*2] |->
      transmitChainOff == $past(functionControlLatch[6])) else $error("tx soft sleep wrong");
   // Pins pass a synchroniser, so only a settled pin is judged
   rx_pin_a: assert property ((functionControlLatch[11:10] == 2'b11 && $stable(receiveChainSleepPin))[*6]
      |-> receiveChainOff == !receiveChainSleepPin) else $error("rx pin sleep wrong");
   tx_pin_a: assert property ((functionControlLatch[11:10] == 2'b11 && $stable(transmitChainSleepPin))[*6]
      |-> transmitChainOff == !transmitChainSleepPin) else $error("tx pin sleep wrong");
   method_flag_a: assert property ($stable(functionControlLatch)[*2] |->
      methodReserved == ^functionControlLatch[11:10]) else $error("method flag wrong");
   load_cause_a: assert property ($changed({functionControlLatch, swallowRatio, mainRatio, referenceRatio})
      |-> $past(loadStrobe, 2)) else $error("latch changed without strobe");
   one_target_a: assert property ($changed(functionControlLatch) |->
      $stable({swallowRatio, mainRatio, referenceRatio})) else $error("two latches loaded");
endmodule // synth_port_chk
bind synth_serial_program_port synth_port_chk chk (.*);

//--- verif/serial_host_model.sv
/* Host model driving serial clock, data and strobe.
   Assumes the caller waits for each word to finish. */
`timescale 1ns/1ns
module serial_host_model (
   output logic serialClock = 0,
   output logic serialData = 0,
   output logic loadStrobe = 0
);
   // Clock stands low between words; odd offset keeps it unrelated to mclk
   task send(input logic [19:0] w);
      #13;
      for (int k = 19; k >= 0; k--) begin
         serialData = w[k];
         #80 serialClock = 1;
         #160 serialClock = 0;
         #80;
      end
      serialData = ~w[0];
      #160 loadStrobe = 1;
      #160 loadStrobe = 0;
   endtask
endmodule // serial_host_model

//--- verif/tb_synth_serial_program_port.sv
/* Testbench for the serial programming port.
   Assumes the host model and checker are compiled alongside. */
`timescale 1ns/1ns
module tb_synth_serial_program_port;
   logic        mclk = 0, rst = 1, rxPin = 1, txPin = 1;
   wire  [51:0] obs;
   wire         serialClock, serialData, loadStrobe;
   int          errors = 0, tests_run = 0;
   // Word, {rx pin, tx pin}, then expected outputs; upper word bits are junk on purpose
   // Main 7 is at least swallow 5, and swallow stays below either modulus
   logic [73:0] rows [6] = '{{20'hfc714, 2'b11, 18'h0, 6'h5, 6'h7, 6'h0, 13'd229, 3'b000},
      {20'hffffe, 2'b11, 18'h0, 6'h5, 6'h7, 6'h3f, 13'd229, 3'b000},
      {20'h00085, 2'b11, 18'h21, 6'h5, 6'h7, 6'h3f, 13'd453, 3'b100},
      {20'h03103, 2'b01, 18'hc40, 6'h5, 6'h7, 6'h3f, 13'd229, 3'b100},
      {20'h03103, 2'b10, 18'hc40, 6'h5, 6'h7, 6'h3f, 13'd229, 3'b010},
      {20'h01101, 2'b11, 18'h440, 6'h5, 6'h7, 6'h3f, 13'd229, 3'b011}};
   synth_serial_program_port uut (.mclk(mclk), .rst(rst), .serialClock(serialClock), .serialData(serialData),
      .loadStrobe(loadStrobe), .receiveChainSleepPin(rxPin), .transmitChainSleepPin(txPin),
      .functionControlLatch(obs[51:34]), .swallowRatio(obs[33:28]), .mainRatio(obs[27:22]),
      .referenceRatio(obs[21:16]), .feedbackDivide(obs[15:3]), .receiveChainOff(obs[2]),
      .transmitChainOff(obs[1]), .methodReserved(obs[0]));
   serial_host_model host (.serialClock(serialClock), .serialData(serialData), .loadStrobe(loadStrobe));
   initial forever #20 mclk = ~mclk;
   task chk(input logic [51:0] exp);
      tests_run++;
      if (obs !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, obs, exp);
      end
   endtask
   task end_sim;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      @(negedge mclk) rst = 0;
      repeat (3) @(negedge mclk);
      foreach (rows[i]) begin
         {rxPin, txPin} = rows[i][53:52];
         host.send(rows[i][73:54]);
         repeat (8) @(negedge mclk);
         chk(rows[i][51:0]);
         $display("row %0d done", i);
      end
      rst = 1;
      repeat (2) @(negedge mclk);
      rst = 0;
      @(negedge mclk);
      chk(52'h0);
      $display("reset test done");
      end_sim;
   end
   initial begin
      #100000;
      errors++;
      end_sim;
   end
endmodule // tb_synth_serial_program_port
